// ==== sim/etr_extended_timer_regs_props.sv ====
// Purpose: port-level assertions for the extended timer register block
// Assumes: control bytes change only through the register port
// Notes:   shadows of both control bytes stand in for hidden state
`timescale 1ns/100ps
`include "etr_defs.svh"

module etr_extended_timer_regs_props (
  input wire logic       mclk,
  input wire logic       reset_n,
  input wire logic [7:0] regAddr,
  input wire logic       regWrite,
  input wire logic       regRead,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic       captureInPinOne,
  input wire logic       captureInPinTwo,
  input wire logic       externalTimerClockPin,
  input wire logic       compareOutPinOne,
  input wire logic       compareOutPinTwo,
  input wire logic       compareOnePinEnable,
  input wire logic       compareTwoPinEnable,
  input wire logic       timerIrq
);
  logic [7:0] ctrlOne_r;
  logic [7:0] ctrlTwo_r;
  wire        wrCtrlOne;
  wire        wrCtrlTwo;
  assign wrCtrlOne = regWrite && (regAddr == `ETR_CTRL1_OFS);
  assign wrCtrlTwo = regWrite && (regAddr == `ETR_CTRL2_OFS);

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      ctrlOne_r <= 8'h00;
      ctrlTwo_r <= 8'h00;
    end
    else
    begin
      if (wrCtrlOne) ctrlOne_r <= regWdata;
      if (wrCtrlTwo) ctrlTwo_r <= regWdata;
    end
  end

  // ======
  // properties
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  property p_resvZero;
    regRead && regAddr == `ETR_FLAGS_OFS ##1 !regRead |=> regRdata[2:0] == 3'h0;
  endproperty
  a_resvZero: assert property (p_resvZero)
    else $error("status low bits not zero");
  // force bits are strobes, so they never read back
  property p_ctrlOneRd;
    regRead && regAddr == `ETR_CTRL1_OFS ##1 !regRead |=> regRdata == ($past(ctrlOne_r, 2) & 8'he7);
  endproperty
  a_ctrlOneRd: assert property (p_ctrlOneRd)
    else $error("control one readback wrong");
  property p_ctrlTwoRd;
    regRead && regAddr == `ETR_CTRL2_OFS ##1 !regRead |=> regRdata == $past(ctrlTwo_r, 2);
  endproperty
  a_ctrlTwoRd: assert property (p_ctrlTwoRd)
    else $error("control two readback wrong");
  property p_pinEn;
    compareOnePinEnable == $past(ctrlTwo_r[7]) && compareTwoPinEnable == $past(ctrlTwo_r[6]);
  endproperty
  a_pinEn: assert property (p_pinEn)
    else $error("pin enables differ from control two");
  property p_forceOne;
    wrCtrlOne && regWdata[3] |=> compareOutPinOne == $past(regWdata[0]);
  endproperty
  a_forceOne: assert property (p_forceOne)
    else $error("forced level missing on pin one");
  property p_forceTwo;
    wrCtrlOne && regWdata[4] |=> compareOutPinTwo == $past(regWdata[2]);
  endproperty
  a_forceTwo: assert property (p_forceTwo)
    else $error("forced level missing on pin two");
  property p_irqOff;
    (ctrlOne_r[7:5] == 3'h0) [*3] |-> !timerIrq;
  endproperty
  a_irqOff: assert property (p_irqOff)
    else $error("interrupt with all enables clear");
  property p_irqCause;
    $rose(timerIrq) |-> $past(ctrlOne_r[7:5]) != 3'h0;
  endproperty
  a_irqCause: assert property (p_irqCause)
    else $error("interrupt rose without an enable");

  c_irq: cover property ($rose(timerIrq));
  c_pin: cover property ($rose(compareOutPinOne));
  c_force: cover property (wrCtrlOne && regWdata[3]);
endmodule

// ==== sim/tb_extended_timer_regs.sv ====
// Purpose: directed bench for the extended timer register block
// Assumes: one strobe at a time, inputs moved on falling mclk
// Notes:   prescaler phase is unknown, so tick counts allow slack
`timescale 1ns/100ps
`include "etr_defs.svh"

module tb_extended_timer_regs;
  logic       mclk = 1'b0;
  logic       reset_n = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic       regWrite = 1'b0;
  logic       regRead = 1'b0;
  logic [7:0] regWdata = 8'h00;
  logic [7:0] regRdata;
  logic       capOne = 1'b0;
  logic       capTwo = 1'b0;
  logic       external_timer_clock_pin = 1'b0;
  logic       pinOne;
  logic       pinTwo;
  logic       enOne;
  logic       enTwo;
  logic       timerIrq;
  logic [7:0] d;
  int         mismatches = 0;
  int         compares = 0;
  int         hi;
  int         lo;

  always #4 mclk = ~mclk;

  etr_extended_timer_regs dut (.mclk(mclk), .reset_n(reset_n), .regAddr(regAddr), .regWrite(regWrite),
    .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata), .captureInPinOne(capOne),
    .captureInPinTwo(capTwo), .externalTimerClockPin(external_timer_clock_pin), .compareOutPinOne(pinOne),
    .compareOutPinTwo(pinTwo), .compareOnePinEnable(enOne), .compareTwoPinEnable(enTwo), .timerIrq(timerIrq));

  // ======
  // helpers
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic near(string name, int exp, int got, int tol);
    compares++;
    if (got < exp - tol || got > exp + tol)
    begin
      mismatches++;
      $display("unexpected %s expected %0d seen %0d", name, exp, got);
    end
  endtask
  task automatic hang(string name);
    mismatches++;
    $display("unexpected %s expected 1 seen 0", name);
    summarize();
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] v);
    @(negedge mclk);
    regAddr = a;
    regWdata = v;
    regWrite = 1'b1;
    @(negedge mclk);
    regWrite = 1'b0;
  endtask
  task automatic rd(logic [7:0] a, output logic [7:0] v);
    @(negedge mclk);
    regAddr = a;
    regRead = 1'b1;
    @(negedge mclk);
    regRead = 1'b0;
    @(negedge mclk);
    v = regRdata;
  endtask
  task automatic waitIrq();
    int n;
    n = 0;
    while (timerIrq !== 1'b1 && n < 200)
    begin
      cyc(1);
      n++;
    end
    if (n == 200) hang("timerIrq");
  endtask
  // pin one high and low widths; low saturates at 80 for a lone pulse
  task automatic measure(output int h, output int l);
    int n;
    n = 0;
    while (pinOne !== 1'b0 && n < 100)
    begin
      cyc(1);
      n++;
    end
    while (pinOne !== 1'b1 && n < 200)
    begin
      cyc(1);
      n++;
    end
    if (n == 200) hang("pin one rise");
    for (h = 0; pinOne === 1'b1 && h < 80; h++) cyc(1);
    for (l = 0; pinOne === 1'b0 && l < 80; l++) cyc(1);
  endtask

  // ======
  // scenarios
  task automatic t_reset();
    logic [7:0] a [6] = '{8'hf8, 8'hf9, 8'hfa, 8'hfb, 8'hfc, 8'hfd};
    logic [7:0] e [6] = '{8'h80, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00};
    rd(8'hfe, d);
    chk("reset flags", 8'h00, d);
    rd(8'hf5, d);
    chk("reset counter low", 8'hfc, d & 8'hfe);
    rd(8'hf4, d);
    chk("reset counter high", 8'hff, d);
    for (int i = 0; i < 6; i++)
    begin
      rd(a[i], d);
      chk("reset register", e[i], d);
    end
    $display("test reset done");
  endtask
  task automatic t_restart();
    wr(8'hfd, 8'h08);
    cyc(20);
    wr(8'hf5, 8'h00);
    rd(8'hf5, d);
    chk("restart low", 8'hfc, d & 8'hfe);
    cyc(20);
    wr(8'hf7, 8'h00);
    rd(8'hf7, d);
    chk("restart alternate", 8'hfc, d & 8'hfe);
    $display("test restart done");
  endtask
  task automatic t_overflow();
    rd(8'hfe, d);
    rd(8'hf5, d);
    wr(8'hfc, 8'h20);
    wr(8'hfd, 8'h04);
    wr(8'hf5, 8'h00);
    waitIrq();
    rd(8'hfe, d);
    chk("overflow flags", 8'h20, d);
    rd(8'hf7, d);
    rd(8'hfe, d);
    chk("flags after alternate", 8'h20, d);
    rd(8'hf5, d);
    rd(8'hfe, d);
    chk("flags after clear", 8'h00, d);
    cyc(3);
    chk("irq after clear", 8'h00, {7'h0, timerIrq});
    $display("test overflow done");
  endtask
  task automatic t_compare();
    wr(8'hf8, 8'h00);
    wr(8'hf9, 8'h02);
    wr(8'hfa, 8'h00);
    wr(8'hfb, 8'h04);
    wr(8'hfc, 8'h45);
    wr(8'hfd, 8'hc4);
    wr(8'hf5, 8'h00);
    waitIrq();
    cyc(4);
    rd(8'hf9, d);
    rd(8'hfb, d);
    rd(8'hfe, d);
    chk("match flags", 8'h68, d);
    chk("match pins", 8'h03, {6'h0, pinOne, pinTwo});
    chk("pin enables", 8'h03, {6'h0, enOne, enTwo});
    rd(8'hf9, d);
    rd(8'hfb, d);
    rd(8'hf5, d);
    rd(8'hfe, d);
    chk("flags cleared", 8'h00, d);
    chk("irq cleared", 8'h00, {7'h0, timerIrq});
    $display("test compare done");
  endtask
  task automatic t_force();
    wr(8'hfc, 8'h1c);
    cyc(2);
    chk("forced pins", 8'h01, {6'h0, pinOne, pinTwo});
    wr(8'hfc, 8'h09);
    cyc(2);
    chk("forced pin one", 8'h03, {6'h0, pinOne, pinTwo});
    rd(8'hfc, d);
    chk("control one read", 8'h01, d);
    $display("test force done");
  endtask
  task automatic t_capture();
    wr(8'hfc, 8'h82);
    wr(8'hfd, 8'h04);
    capTwo = 1'b1;
    cyc(8);
    rd(8'hfe, d);
    chk("no rising capture two", 8'h00, d);
    capOne = 1'b1;
    waitIrq();
    cyc(2);
    rd(8'hfe, d);
    chk("capture one", 8'h80, d);
    capTwo = 1'b0;
    cyc(8);
    rd(8'hfe, d);
    chk("capture two", 8'h90, d);
    rd(8'hf1, d);
    rd(8'hf3, d);
    rd(8'hfe, d);
    chk("captures cleared", 8'h00, d);
    capOne = 1'b0;
    cyc(8);
    rd(8'hfe, d);
    chk("no falling capture one", 8'h00, d);
    $display("test capture done");
  endtask
  task automatic t_clock();
    int div [3] = '{4, 2, 8};
    for (int i = 0; i < 3; i++)
    begin
      wr(8'hfd, {4'h0, i[1:0], 2'h0});
      wr(8'hf5, 8'h00);
      cyc(46);
      rd(8'hf5, d);
      near("prescaled ticks", 48 / div[i], 8'(d - 8'hfc), 1);
    end
    for (int e = 1; e >= 0; e--)
    begin
      wr(8'hfd, {7'h06, e[0]});
      external_timer_clock_pin = 1'b1;
      cyc(6);
      wr(8'hf5, 8'h00);
      external_timer_clock_pin = 1'b0;
      cyc(6);
      external_timer_clock_pin = 1'b1;
      cyc(6);
      external_timer_clock_pin = 1'b0;
      cyc(6);
      rd(8'hf5, d);
      chk("external ticks", 8'hfe - e[7:0], d);
    end
    $display("test clock done");
  endtask
  task automatic t_pulse();
    logic [7:0] m [2] = '{8'h94, 8'hb4};
    wr(8'hfc, 8'h04);
    // compare flags left by the clock test: status read, then both low bytes
    rd(8'hfe, d);
    rd(8'hf9, d);
    wr(8'hfb, 8'h06);
    for (int i = 0; i < 2; i++)
    begin
      wr(8'hfd, m[i]);
      wr(8'hf5, 8'h00);
      measure(hi, lo);
      near("pulse high", 12, hi, 2);
      near("pulse low", 8, lo, 2);
    end
    rd(8'hfe, d);
    chk("no compare flags", 8'h00, d & 8'h48);
    wr(8'hfd, 8'ha4);
    wr(8'hfc, 8'h0e);
    cyc(4);
    capOne = 1'b1;
    measure(hi, lo);
    near("single high", 12, hi, 2);
    near("single low", 80, lo, 0);
    $display("test pulse done");
  endtask

  initial
  begin
    cyc(10);
    reset_n = 1'b1;
    t_reset();
    t_restart();
    t_overflow();
    t_compare();
    t_force();
    t_capture();
    t_clock();
    t_pulse();
    summarize();
  end
endmodule

bind etr_extended_timer_regs etr_extended_timer_regs_props u_props (.mclk(mclk), .reset_n(reset_n),
  .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
  .captureInPinOne(captureInPinOne), .captureInPinTwo(captureInPinTwo),
  .externalTimerClockPin(externalTimerClockPin), .compareOutPinOne(compareOutPinOne),
  .compareOutPinTwo(compareOutPinTwo), .compareOnePinEnable(compareOnePinEnable),
  .compareTwoPinEnable(compareTwoPinEnable), .timerIrq(timerIrq));

// ==== verilog/etr_defs.svh ====
// Purpose: offsets, field positions and reset values of the extended timer registers
// Assumes: byte-wide register port, 8-bit register index
// Notes:   definitions only
`ifndef ETR_DEFS_SVH
`define ETR_DEFS_SVH

// =====================================================================
// register offsets
`define ETR_CAP1_HI_OFS   8'hf0
`define ETR_CAP1_LO_OFS   8'hf1
`define ETR_CAP2_HI_OFS   8'hf2
`define ETR_CAP2_LO_OFS   8'hf3
`define ETR_CNT_HI_OFS    8'hf4
`define ETR_CNT_LO_OFS    8'hf5
`define ETR_ACNT_HI_OFS   8'hf6
`define ETR_ACNT_LO_OFS   8'hf7
`define ETR_CMP1_HI_OFS   8'hf8
`define ETR_CMP1_LO_OFS   8'hf9
`define ETR_CMP2_HI_OFS   8'hfa
`define ETR_CMP2_LO_OFS   8'hfb
`define ETR_CTRL1_OFS     8'hfc
`define ETR_CTRL2_OFS     8'hfd
`define ETR_FLAGS_OFS     8'hfe

// =====================================================================
// reset values and counter limits
`define ETR_CNT_RST       16'hfffc
`define ETR_CMP_HI_RST    8'h80
`define ETR_CMP_LO_RST    8'h00
`define ETR_CTRL_RST      8'h00
`define ETR_CNT_TOP       16'hffff
`define ETR_CNT_WRAP      16'h0000

// =====================================================================
// interrupt_and_level_control fields
`define ETR_C1_CAP_IE     7
`define ETR_C1_CMP_IE     6
`define ETR_C1_OVF_IE     5
`define ETR_C1_FORCE2     4
`define ETR_C1_FORCE1     3
`define ETR_C1_LEVEL2     2
`define ETR_C1_CAP1_EDGE  1
`define ETR_C1_LEVEL1     0

// =====================================================================
// mode_and_clock_control fields
`define ETR_C2_PIN1_EN    7
`define ETR_C2_PIN2_EN    6
`define ETR_C2_ONE_PULSE  5
`define ETR_C2_PWM        4
`define ETR_C2_CLK_HI     3
`define ETR_C2_CLK_LO     2
`define ETR_C2_CAP2_EDGE  1
`define ETR_C2_EXT_EDGE   0

// =====================================================================
// event_flags fields
`define ETR_F_CAP1        7
`define ETR_F_CMP1        6
`define ETR_F_OVF         5
`define ETR_F_CAP2        4
`define ETR_F_CMP2        3

// =====================================================================
// prescaler terminal counts (divide minus one)
`define ETR_DIV2_LAST     3'h1
`define ETR_DIV4_LAST     3'h3
`define ETR_DIV8_LAST     3'h7

`endif

// ==== verilog/etr_extended_timer_regs.sv ====
// Purpose: 16-bit free-running timer, two captures, two compares, byte register file
// Assumes: core clock mclk, synchronous reset_n, one register access per strobe
// Notes:   read data appears the cycle after regRead
`timescale 1ns/100ps
`include "etr_defs.svh"

module etr_extended_timer_regs (
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic [7:0] regAddr,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  input  wire logic [7:0] regWdata,
  output logic      [7:0] regRdata,
  input  wire logic       captureInPinOne,
  input  wire logic       captureInPinTwo,
  input  wire logic       externalTimerClockPin,
  output logic            compareOutPinOne,
  output logic            compareOutPinTwo,
  output logic            compareOnePinEnable,
  output logic            compareTwoPinEnable,
  output logic            timerIrq
);

  // =====================================================================
  // registers
  logic [15:0] count_r;
  logic [15:0] captureValueOne_r;
  logic [15:0] captureValueTwo_r;
  logic [7:0]  cmpOneHi_r;
  logic [7:0]  cmpOneLo_r;
  logic [7:0]  cmpTwoHi_r;
  logic [7:0]  cmpTwoLo_r;
  logic [7:0]  ctrl1_r;
  logic [7:0]  ctrl2_r;
  logic [4:0]  flags_r;
  logic [4:0]  armed_r;
  logic        cmpOneHold_r;
  logic        cmpTwoHold_r;
  logic [2:0]  prescale_r;
  logic        moved_r;
  logic [2:0]  extSync_r;
  logic [2:0]  capOneSync_r;
  logic [2:0]  capTwoSync_r;
  etr_pkg::etr_pulse_t pulseState_r;
  etr_pkg::etr_pulse_t pulseState_nxt;

  // =====================================================================
  // register decode
  wire access      = regWrite | regRead;
  wire wrCntLo     = regWrite && (regAddr == `ETR_CNT_LO_OFS);
  wire wrAcntLo    = regWrite && (regAddr == `ETR_ACNT_LO_OFS);
  wire wrCmpOneHi  = regWrite && (regAddr == `ETR_CMP1_HI_OFS);
  wire wrCmpOneLo  = regWrite && (regAddr == `ETR_CMP1_LO_OFS);
  wire wrCmpTwoHi  = regWrite && (regAddr == `ETR_CMP2_HI_OFS);
  wire wrCmpTwoLo  = regWrite && (regAddr == `ETR_CMP2_LO_OFS);
  wire wrCtrl1     = regWrite && (regAddr == `ETR_CTRL1_OFS);
  wire wrCtrl2     = regWrite && (regAddr == `ETR_CTRL2_OFS);
  wire rdFlags     = regRead && (regAddr == `ETR_FLAGS_OFS);

  // low-byte accesses that may clear a flag armed by a status read
  wire [4:0] lowTouch;
  assign lowTouch[0] = access && (regAddr == `ETR_CMP2_LO_OFS);
  assign lowTouch[1] = access && (regAddr == `ETR_CAP2_LO_OFS);
  assign lowTouch[2] = access && (regAddr == `ETR_CNT_LO_OFS);
  assign lowTouch[3] = access && (regAddr == `ETR_CMP1_LO_OFS);
  assign lowTouch[4] = access && (regAddr == `ETR_CAP1_LO_OFS);

  // =====================================================================
  // mode decode
  wire pwmMode      = ctrl2_r[`ETR_C2_PWM];
  wire onePulseMode = ctrl2_r[`ETR_C2_ONE_PULSE] & ~pwmMode;
  wire pinOneEn     = ctrl2_r[`ETR_C2_PIN1_EN];
  wire pinTwoEn     = ctrl2_r[`ETR_C2_PIN2_EN];
  wire [1:0] clkSelBits = ctrl2_r[`ETR_C2_CLK_HI:`ETR_C2_CLK_LO];
  etr_pkg::etr_clk_sel_t clkSel;
  assign clkSel = etr_pkg::etr_clk_sel_t'(clkSelBits);

  // =====================================================================
  // counter clock: prescaler or synchronised external pin
  // first stage feeds only the second; edges come from stages two and three
  // pin must hold each level for more than one mclk period or edges are lost
  wire extRise  = extSync_r[1] & ~extSync_r[2];
  wire extFall  = ~extSync_r[1] & extSync_r[2];
  wire extEdge  = ctrl2_r[`ETR_C2_EXT_EDGE] ? extRise : extFall;
  wire [2:0] divLast = (clkSel == etr_pkg::CLK_DIV2) ? `ETR_DIV2_LAST :
                       (clkSel == etr_pkg::CLK_DIV8) ? `ETR_DIV8_LAST :
                                                       `ETR_DIV4_LAST;
  wire preTick  = (prescale_r >= divLast);
  wire tick     = (clkSel == etr_pkg::CLK_EXT) ? extEdge : preTick;
  wire [2:0] prescale_nxt = preTick ? 3'h0 : prescale_r + 3'h1;

  // =====================================================================
  // capture edges
  wire capOneRise = capOneSync_r[1] & ~capOneSync_r[2];
  wire capOneFall = ~capOneSync_r[1] & capOneSync_r[2];
  wire capTwoRise = capTwoSync_r[1] & ~capTwoSync_r[2];
  wire capTwoFall = ~capTwoSync_r[1] & capTwoSync_r[2];
  wire capOneHit  = ctrl1_r[`ETR_C1_CAP1_EDGE] ? capOneRise : capOneFall;
  wire capTwoHit  = ctrl2_r[`ETR_C2_CAP2_EDGE] ? capTwoRise : capTwoFall;

  // =====================================================================
  // compares: judged on the counter value just reached, so one hit per tick
  // hold masks a half-written value: write high byte first, then low
  wire [15:0] cmpOne = {cmpOneHi_r, cmpOneLo_r};
  wire [15:0] cmpTwo = {cmpTwoHi_r, cmpTwoLo_r};
  wire cmpOneHit = moved_r && !cmpOneHold_r && (count_r == cmpOne);
  wire cmpTwoHit = moved_r && !cmpTwoHold_r && (count_r == cmpTwo);
  wire overflow  = tick && (count_r == `ETR_CNT_TOP);

  // prescaler keeps its phase on restart, so the first tick may come early
  // restart: software write, pulse-width period end, or single pulse trigger
  wire pulseStart = onePulseMode && capOneHit;
  wire restart    = wrCntLo || wrAcntLo
                    || (pwmMode && cmpTwoHit)
                    || pulseStart;
  wire [15:0] count_nxt = restart ? `ETR_CNT_RST :
                          tick    ? count_r + 16'h0001 :
                                    count_r;

  // =====================================================================
  // flags: set wins over clear; compare flags stay quiet in pulse-width mode
  wire [4:0] flagSet;
  assign flagSet[0] = cmpTwoHit && !pwmMode;
  assign flagSet[1] = capTwoHit;
  assign flagSet[2] = overflow;
  assign flagSet[3] = cmpOneHit && !pwmMode;
  assign flagSet[4] = capOneHit;

  logic [4:0] flags_nxt;
  logic [4:0] armed_nxt;
  // only flags set at the status read are armed; a later event survives
  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1)
    begin : gFlag
      wire clearIt = armed_r[g] && lowTouch[g];
      assign flags_nxt[g] = flagSet[g] | (flags_r[g] & ~clearIt);
      assign armed_nxt[g] = rdFlags ? flags_r[g] : (armed_r[g] & ~lowTouch[g]);
    end
  endgenerate

  wire [7:0] flagsView = {flags_r[4], flags_r[3], flags_r[2], flags_r[1], flags_r[0], 3'h0};

  // =====================================================================
  // interrupt request
  // each enable gates its own flags; the request is a level, not a pulse
  wire capReq  = ctrl1_r[`ETR_C1_CAP_IE] && (flags_r[4] || flags_r[1]);
  wire cmpReq  = ctrl1_r[`ETR_C1_CMP_IE] && (flags_r[3] || flags_r[0]);
  wire ovfReq  = ctrl1_r[`ETR_C1_OVF_IE] && flags_r[2];
  wire irq_nxt = capReq || cmpReq || ovfReq;

  // =====================================================================
  // single pulse sequencer
  always_comb
  begin
    pulseState_nxt = pulseState_r;
    case (pulseState_r)
      etr_pkg::PULSE_IDLE:
        if (pulseStart)
          pulseState_nxt = etr_pkg::PULSE_ACTIVE;
      etr_pkg::PULSE_ACTIVE:
        if (!onePulseMode || cmpOneHit)
          pulseState_nxt = etr_pkg::PULSE_IDLE;
      default:
        pulseState_nxt = etr_pkg::PULSE_IDLE;
    endcase
  end

  // =====================================================================
  // compare pins; a force written with its level takes the new level
  wire forceOne = wrCtrl1 && regWdata[`ETR_C1_FORCE1];
  wire forceTwo = wrCtrl1 && regWdata[`ETR_C1_FORCE2];
  wire endPulse = cmpOneHit && (pwmMode || pulseState_r == etr_pkg::PULSE_ACTIVE);
  wire beginPulse = (pwmMode && cmpTwoHit) || pulseStart;
  // plain compare action; single pulse owns pin one while selected
  wire plainOne   = cmpOneHit && pinOneEn && !onePulseMode;
  wire plainTwo   = cmpTwoHit && pinTwoEn;
  wire pinOne_nxt = forceOne   ? regWdata[`ETR_C1_LEVEL1] :
                    beginPulse ? ctrl1_r[`ETR_C1_LEVEL2] :
                    endPulse   ? ctrl1_r[`ETR_C1_LEVEL1] :
                    plainOne   ? ctrl1_r[`ETR_C1_LEVEL1] :
                                 compareOutPinOne;
  wire pinTwo_nxt = forceTwo   ? regWdata[`ETR_C1_LEVEL2] :
                    plainTwo   ? ctrl1_r[`ETR_C1_LEVEL2] :
                                 compareOutPinTwo;

  // =====================================================================
  // read mux; counter high is live, so read low right after high for a pair
  wire [7:0] rd_nxt =
    (regAddr == `ETR_CAP1_HI_OFS) ? captureValueOne_r[15:8] :
    (regAddr == `ETR_CAP1_LO_OFS) ? captureValueOne_r[7:0] :
    (regAddr == `ETR_CAP2_HI_OFS) ? captureValueTwo_r[15:8] :
    (regAddr == `ETR_CAP2_LO_OFS) ? captureValueTwo_r[7:0] :
    (regAddr == `ETR_CNT_HI_OFS || regAddr == `ETR_ACNT_HI_OFS) ? count_r[15:8] :
    (regAddr == `ETR_CNT_LO_OFS || regAddr == `ETR_ACNT_LO_OFS) ? count_r[7:0] :
    (regAddr == `ETR_CMP1_HI_OFS) ? cmpOneHi_r :
    (regAddr == `ETR_CMP1_LO_OFS) ? cmpOneLo_r :
    (regAddr == `ETR_CMP2_HI_OFS) ? cmpTwoHi_r :
    (regAddr == `ETR_CMP2_LO_OFS) ? cmpTwoLo_r :
    (regAddr == `ETR_CTRL1_OFS)   ? (ctrl1_r & 8'he7) :
    (regAddr == `ETR_CTRL2_OFS)   ? ctrl2_r :
    (regAddr == `ETR_FLAGS_OFS)   ? flagsView :
                                    8'h00;

  // =====================================================================
  // counter, prescaler and synchronisers
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      count_r      <= `ETR_CNT_RST;
      prescale_r   <= 3'h0;
      moved_r      <= 1'b0;
      extSync_r    <= 3'h0;
      capOneSync_r <= 3'h0;
      capTwoSync_r <= 3'h0;
      pulseState_r <= etr_pkg::PULSE_IDLE;
    end
    else
    begin
      count_r      <= count_nxt;
      prescale_r   <= (clkSel == etr_pkg::CLK_EXT) ? 3'h0 : prescale_nxt;
      moved_r      <= tick && !restart;
      extSync_r    <= {extSync_r[1:0], externalTimerClockPin};
      capOneSync_r <= {capOneSync_r[1:0], captureInPinOne};
      capTwoSync_r <= {capTwoSync_r[1:0], captureInPinTwo};
      pulseState_r <= pulseState_nxt;
    end
  end

  // =====================================================================
  // captures and flags
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      captureValueOne_r <= 16'h0000;
      captureValueTwo_r <= 16'h0000;
      flags_r           <= 5'h00;
      armed_r           <= 5'h00;
    end
    else
    begin
      if (capOneHit)
        captureValueOne_r <= count_r;
      if (capTwoHit)
        captureValueTwo_r <= count_r;
      flags_r <= flags_nxt;
      armed_r <= armed_nxt;
    end
  end

  // =====================================================================
  // software registers
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      cmpOneHi_r   <= `ETR_CMP_HI_RST;
      cmpOneLo_r   <= `ETR_CMP_LO_RST;
      cmpTwoHi_r   <= `ETR_CMP_HI_RST;
      cmpTwoLo_r   <= `ETR_CMP_LO_RST;
      ctrl1_r      <= `ETR_CTRL_RST;
      ctrl2_r      <= `ETR_CTRL_RST;
      cmpOneHold_r <= 1'b0;
      cmpTwoHold_r <= 1'b0;
    end
    else
    begin
      if (wrCmpOneHi)
        cmpOneHi_r <= regWdata;
      if (wrCmpOneLo)
        cmpOneLo_r <= regWdata;
      if (wrCmpTwoHi)
        cmpTwoHi_r <= regWdata;
      if (wrCmpTwoLo)
        cmpTwoLo_r <= regWdata;
      if (wrCtrl1)
        ctrl1_r <= regWdata;
      if (wrCtrl2)
        ctrl2_r <= regWdata;
      cmpOneHold_r <= wrCmpOneHi | (cmpOneHold_r & ~wrCmpOneLo);
      cmpTwoHold_r <= wrCmpTwoHi | (cmpTwoHold_r & ~wrCmpTwoLo);
    end
  end

  // =====================================================================
  // outputs
  // read data holds between reads; pins hold between events
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      regRdata            <= 8'h00;
      compareOutPinOne    <= 1'b0;
      compareOutPinTwo    <= 1'b0;
      compareOnePinEnable <= 1'b0;
      compareTwoPinEnable <= 1'b0;
      timerIrq            <= 1'b0;
    end
    else
    begin
      if (regRead)
        regRdata <= rd_nxt;
      compareOutPinOne    <= pinOne_nxt;
      compareOutPinTwo    <= pinTwo_nxt;
      compareOnePinEnable <= pinOneEn;
      compareTwoPinEnable <= pinTwoEn;
      timerIrq            <= irq_nxt;
    end
  end

endmodule

// ==== verilog/etr_pkg.sv ====
// Purpose: types shared by the extended timer
// Assumes: nothing
// Notes:   constants live in etr_defs.svh
package etr_pkg;

  // =====================================================================
  // counter clock source
  typedef enum logic [1:0] {
    CLK_DIV4 = 2'h0,
    CLK_DIV2 = 2'h1,
    CLK_DIV8 = 2'h2,
    CLK_EXT  = 2'h3
  } etr_clk_sel_t;

  // =====================================================================
  // single pulse sequencer
  typedef enum logic [1:0] {
    PULSE_IDLE   = 2'h1,
    PULSE_ACTIVE = 2'h2
  } etr_pulse_t;

endpackage
